// ===== common/chop_pkg.sv
// Purpose: Shared constants and carriers for the voltage chopper config and
//          load result block.
// Assumes: APB slave with 32-bit words, byte addressed.
// Notes:   Register addresses, reset values, field positions and timing live here.
package chop_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  CFG_ADDR        = 8'h70;
    localparam logic [7:0]  STATUS_ADDR     = 8'h74;
    localparam logic [7:0]  LIMITS_ADDR     = 8'h78;
    localparam logic [7:0]  CTRL_ADDR       = 8'h7c;
    localparam logic [31:0] CFG_RESET       = 32'hc40c001d;
    localparam logic [31:0] LIMITS_RESET    = 32'h00000000;
    localparam logic [31:0] CTRL_RESET      = 32'h00000000;

    // ************************************************************
    // Field positions of voltage_chopper_config
    // ************************************************************
    localparam int LIM_LSB      = 28;
    localparam int GRAD_REG_LSB = 24;
    localparam int DIS_STST_BIT = 23;
    localparam int SD_MEAS_BIT  = 22;
    localparam int COIL_LSB     = 20;
    localparam int AUTOSC_BIT   = 18;
    // Status register fields
    localparam int STST_BIT     = 31;
    localparam int STALL_BIT    = 24;
    localparam int MODE_BIT     = 14;
    // Limits register: lower limit 9:0, upper limit 25:16
    localparam int LOW_LSB      = 0;
    localparam int UP_LSB       = 16;
    // Control register: hold current 4:0, stall clear bit 8
    localparam int HOLD_LSB     = 0;
    localparam int STALL_CLR_BIT = 8;

    // ************************************************************
    // Timing and amplitude width
    // ************************************************************
    localparam int STST_CLOCKS  = 1048576;
    localparam int AMP_W        = 8;

    typedef enum logic [1:0] {
        COIL_NORMAL = 2'b00,
        COIL_FREE   = 2'b01,
        COIL_SHORT_LS = 2'b10,
        COIL_SHORT_HS = 2'b11
    } coil_mode_e;

    // Current scaling requests out of the load comparison
    typedef struct packed {
        logic       inc;
        logic       dec;
    } scale_req_s;

    // Bridge-facing control word
    typedef struct packed {
        coil_mode_e coil;
        logic       reg_hold;
        logic       sd_meas;
    } bridge_s;
endpackage : chop_pkg

// ===== hdl/amp_regulator.sv
// Purpose: Automatic amplitude regulator with gradient-limited step and
//          switch-back cap.
// Assumes: Half-wave pulse is one cycle; target comes from current loop.
// Notes:   Amplitude in half-increments internally (one extra LSB).
`timescale 1ns/100ps
`default_nettype none
module amp_regulator #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         half_wave,
    input  wire logic         enable,
    input  wire logic         hold_reg,
    input  wire logic         switch_back,
    input  wire logic [3:0]   grad_reg,
    input  wire logic [3:0]   lim,
    input  wire logic [W-1:0] target,
    output logic      [W-1:0] amp
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [W:0] acc;
    } amp_state_s;

    amp_state_s st_ff;
    amp_state_s nxt_st;
    logic [W:0]   tgt2;
    logic [W:0]   step;
    logic [W:0]   cap;
    logic [W+1:0] up_sum;
    logic [W+1:0] dn_sum;

    assign tgt2 = {target, 1'b0};
    assign step = {{(W-3){1'b0}}, grad_reg};
    assign cap  = {lim, {(W-3){1'b1}}};
    // Spare top bit so a step near full scale cannot wrap around
    assign up_sum = {1'b0, st_ff.acc} + {1'b0, step};
    assign dn_sum = {1'b0, tgt2} + {1'b0, step};

    // Step toward target by at most grad*0.5 per half wave; the
    // switch-back cycle only caps, so no step slips past the limit
    always_comb begin
        nxt_st = st_ff;
        if (switch_back) begin
            if (st_ff.acc > cap) begin
                nxt_st.acc = cap;
            end
        end else if (enable && half_wave && !hold_reg
                     && grad_reg != 4'h0) begin
            if ({1'b0, tgt2} > up_sum) begin
                nxt_st.acc = up_sum[W:0];
            end else if ({1'b0, st_ff.acc} > dn_sum) begin
                nxt_st.acc = st_ff.acc - step;
            end else begin
                nxt_st.acc = tgt2;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign amp = st_ff.acc[W:1];

    AST_STEP_LIMIT: assert property (@(posedge clk) disable iff (rst)
        !switch_back |=>
            (st_ff.acc - $past(st_ff.acc) <= $past(step)
          || $past(st_ff.acc) - st_ff.acc <= $past(step)))
        else $error("amplitude step exceeds gradient");
    AST_SWITCHBACK_CAP: assert property (@(posedge clk) disable iff (rst)
        switch_back |=> st_ff.acc[W:W-3] <= $past(lim))
        else $error("switch-back cap not applied");
endmodule : amp_regulator
`default_nettype wire

// ===== hdl/chopper_pwm_config_load_result.sv
// Purpose: Voltage chopper configuration register and load result logic.
// Assumes: APB slave, single clock, synchronous active-high reset.
// Notes:   Measurement inputs arrive from the analog front end each cycle.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module chopper_pwm_config_load_result #(
    parameter int STST_CLOCKS = chop_pkg::STST_CLOCKS,
    parameter int RES_W       = 10
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              voltage_mode,
    input  wire logic              step_pulse,
    input  wire logic              half_wave,
    input  wire logic              speed_stall,
    input  wire logic [RES_W-1:0]  spread_load,
    input  wire logic [RES_W-1:0]  volt_load,
    input  wire logic [RES_W-1:0]  coil_a_on_time,
    input  wire logic [7:0]        amp_target,
    output chop_pkg::bridge_s      bridge,
    output chop_pkg::scale_req_s   scale_req,
    output logic                   stall_flag,
    output logic                   stst_flag,
    output logic      [RES_W-1:0]  load_measure_result,
    output logic      [7:0]        amplitude
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [31:0]      cfg;
        logic [31:0]      limits;
        logic [31:0]      ctrl;
        logic [31:0]      rdata;
        logic             ready;
        logic             err;
        logic [20:0]      idle_cnt;
        logic             stst;
        logic             stall;
        logic [RES_W-1:0] result;
        logic             mode_d;
        logic             swb;
        chop_pkg::bridge_s    br;
        chop_pkg::scale_req_s sreq;
    } top_state_s;

    top_state_s st_ff;
    top_state_s nxt_st;

    logic             access;
    logic             wr;
    logic             hit;
    logic [4:0]       hold_cur;
    logic [RES_W-1:0] up_lim;
    logic [RES_W-1:0] low_lim;
    logic [RES_W-1:0] sel_res;
    logic [1:0]       coil_sel;
    logic [7:0]       amp_w;
    logic [20:0]      stst_lim;

    assign access   = psel && penable && !st_ff.ready;
    assign wr       = access && pwrite;
    assign hit      = paddr == chop_pkg::CFG_ADDR
                   || paddr == chop_pkg::STATUS_ADDR
                   || paddr == chop_pkg::LIMITS_ADDR
                   || paddr == chop_pkg::CTRL_ADDR;
    assign hold_cur = st_ff.ctrl[chop_pkg::HOLD_LSB +: 5];
    assign up_lim   = st_ff.limits[chop_pkg::UP_LSB +: RES_W];
    assign low_lim  = st_ff.limits[chop_pkg::LOW_LSB +: RES_W];
    assign coil_sel = st_ff.cfg[chop_pkg::COIL_LSB +: 2];
    assign stst_lim = 21'(STST_CLOCKS);

    // Result source follows chopper mode; coil A on-time at spread standstill
    always_comb begin
        if (voltage_mode) begin
            sel_res = volt_load;
        end else if (st_ff.stst) begin
            sel_res = coil_a_on_time;
        end else begin
            sel_res = spread_load;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.ready = access;
        nxt_st.err   = access && !hit;
        // Writes land in the access cycle; unmapped writes are dropped
        if (wr) begin
            case (paddr)
                chop_pkg::CFG_ADDR:    nxt_st.cfg    = pwdata;
                chop_pkg::LIMITS_ADDR: nxt_st.limits = pwdata;
                chop_pkg::CTRL_ADDR:   nxt_st.ctrl   = pwdata;
                default:               nxt_st.cfg    = st_ff.cfg;
            endcase
        end
        if (access) begin
            case (paddr)
                chop_pkg::CFG_ADDR:    nxt_st.rdata = st_ff.cfg;
                chop_pkg::LIMITS_ADDR: nxt_st.rdata = st_ff.limits;
                chop_pkg::CTRL_ADDR:   nxt_st.rdata = st_ff.ctrl;
                chop_pkg::STATUS_ADDR: begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rdata[chop_pkg::STST_BIT]  = st_ff.stst;
                    nxt_st.rdata[chop_pkg::STALL_BIT] = st_ff.stall;
                    nxt_st.rdata[chop_pkg::MODE_BIT]  = voltage_mode;
                    nxt_st.rdata[RES_W-1:0]           = st_ff.result;
                end
                default:               nxt_st.rdata = 32'h0;
            endcase
        end
        // Stall clear is a self-clearing command bit
        nxt_st.ctrl[chop_pkg::STALL_CLR_BIT] = 1'b0;
        if (wr && paddr == chop_pkg::CTRL_ADDR
                && pwdata[chop_pkg::STALL_CLR_BIT]) begin
            nxt_st.stall = 1'b0;
        end
        // Set wins over the clear so no stall event is lost
        if (sel_res == '0 || speed_stall) begin
            nxt_st.stall = 1'b1;
        end
        nxt_st.result = sel_res;
        // Standstill counter saturates at the limit
        if (step_pulse) begin
            nxt_st.idle_cnt = '0;
            nxt_st.stst     = 1'b0;
        end else if (st_ff.idle_cnt < stst_lim) begin
            nxt_st.idle_cnt = st_ff.idle_cnt + 21'h1;
            nxt_st.stst     = (st_ff.idle_cnt + 21'h1) >= stst_lim;
        end
        // Smart current scaling requests
        nxt_st.sreq.inc = sel_res < low_lim;
        nxt_st.sreq.dec = sel_res > up_lim;
        // Switch-back pulse on spread to voltage transition
        nxt_st.mode_d = voltage_mode;
        nxt_st.swb    = voltage_mode && !st_ff.mode_d;
        // Bridge control
        nxt_st.br.sd_meas  = st_ff.cfg[chop_pkg::SD_MEAS_BIT];
        nxt_st.br.reg_hold = st_ff.cfg[chop_pkg::DIS_STST_BIT]
                          && st_ff.stst && hold_cur != 5'h0;
        if (hold_cur == 5'h0 && st_ff.stst) begin
            nxt_st.br.coil = chop_pkg::coil_mode_e'(coil_sel);
        end else begin
            nxt_st.br.coil = chop_pkg::COIL_NORMAL;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff        <= '0;
            st_ff.cfg    <= chop_pkg::CFG_RESET;
            st_ff.limits <= chop_pkg::LIMITS_RESET;
            st_ff.ctrl   <= chop_pkg::CTRL_RESET;
            st_ff.mode_d <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // Amplitude regulator
    // ************************************************************
    amp_regulator #(
        .W (chop_pkg::AMP_W)
    ) u_amp (
        .clk         (clk),
        .rst         (rst),
        .half_wave   (half_wave),
        .enable      (st_ff.cfg[chop_pkg::AUTOSC_BIT]),
        .hold_reg    (st_ff.br.reg_hold),
        .switch_back (st_ff.swb),
        .grad_reg    (st_ff.cfg[chop_pkg::GRAD_REG_LSB +: 4]),
        .lim         (st_ff.cfg[chop_pkg::LIM_LSB +: 4]),
        .target      (amp_target),
        .amp         (amp_w)
    );

    // Regulator output is a flop inside the submodule
    assign amplitude           = amp_w;
    assign prdata              = st_ff.rdata;
    assign pready              = st_ff.ready;
    assign pslverr             = st_ff.err;
    assign bridge              = st_ff.br;
    assign scale_req           = st_ff.sreq;
    assign stall_flag          = st_ff.stall;
    assign stst_flag           = st_ff.stst;
    assign load_measure_result = st_ff.result;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_STALL_ZERO: assert property (@(posedge clk) disable iff (rst)
        (sel_res == '0) |=> stall_flag)
        else $error("zero load did not set stall");
    AST_STALL_CSPD: assert property (@(posedge clk) disable iff (rst)
        speed_stall |=> stall_flag)
        else $error("speed stall not flagged");
    AST_RESULT_VOLT: assert property (@(posedge clk) disable iff (rst)
        voltage_mode |=> load_measure_result == $past(volt_load))
        else $error("voltage mode result source wrong");
    AST_NO_SPREAD: assert property (@(posedge clk) disable iff (rst)
        (voltage_mode && volt_load != spread_load)
        |=> load_measure_result != $past(spread_load))
        else $error("spread result used in voltage mode");
    AST_STST_ONTIME: assert property (@(posedge clk) disable iff (rst)
        (!voltage_mode && stst_flag)
        |=> load_measure_result == $past(coil_a_on_time))
        else $error("standstill on-time not shown");
    AST_SCALE_LOW: assert property (@(posedge clk) disable iff (rst)
        (sel_res < low_lim) |=> scale_req.inc)
        else $error("lower limit not acted on");
    AST_STST_CLEAR: assert property (@(posedge clk) disable iff (rst)
        step_pulse |=> !stst_flag)
        else $error("standstill survived step");
    AST_COIL_HOLD: assert property (@(posedge clk) disable iff (rst)
        (hold_cur != 5'h0) |=> bridge.coil == chop_pkg::COIL_NORMAL)
        else $error("coil mode active with hold current");
    AST_COIL_SEL: assert property (@(posedge clk) disable iff (rst)
        (hold_cur == 5'h0 && stst_flag) |=> bridge.coil == $past(coil_sel))
        else $error("coil mode not applied");
    AST_SD_MEAS: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> bridge.sd_meas == $past(st_ff.cfg[chop_pkg::SD_MEAS_BIT]))
        else $error("slow decay enable not forwarded");
    AST_REG_HOLD: assert property (@(posedge clk) disable iff (rst)
        (!st_ff.cfg[chop_pkg::DIS_STST_BIT]) |=> !bridge.reg_hold)
        else $error("regulation held while allowed");
endmodule : chopper_pwm_config_load_result
`default_nettype wire

// ===== test/coil_model.sv
// Purpose: Motor coil and bridge stand-in feeding the load measurements.
// Assumes: The bench sets the mechanical load level directly.
// Notes:   On-time reads zero while the coils are not driven normally.
`timescale 1ns/100ps
`default_nettype none
module coil_model #(
    parameter logic [9:0] ON_TIME  = 10'h155,
    parameter logic [9:0] V_OFFSET = 10'h040
) (
    input  wire chop_pkg::bridge_s bridge,
    input  wire logic [9:0]        load_level,
    output logic      [9:0]        spread_load,
    output logic      [9:0]        volt_load,
    output logic      [9:0]        coil_a_on_time
);
    // ****************************************
    // Measurement paths
    // ****************************************
    // Voltage path biased so a wrong path choice shows at once
    assign spread_load    = load_level;
    assign volt_load      = load_level + V_OFFSET;
    // Freewheeling or shorted coils see no chopper on-time
    assign coil_a_on_time = (bridge.coil == chop_pkg::COIL_NORMAL) ?
                            ON_TIME : 10'h000;
endmodule : coil_model
`default_nettype wire

// ===== test/chopper_pwm_config_load_result_tb.sv
// Purpose: Self-checking bench for the chopper config and load result.
// Assumes: One APB wait state; standstill count shortened to 16.
// Notes:   Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/100ps
`default_nettype none
module chopper_pwm_config_load_result_tb;
    localparam int STST = 16;
    logic                 clk          = 1'b0;
    logic                 rst          = 1'b1;
    logic                 psel         = 1'b0;
    logic                 penable      = 1'b0;
    logic                 pwrite       = 1'b0;
    logic [7:0]           paddr        = 8'h00;
    logic [31:0]          pwdata       = 32'h0;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 voltage_mode = 1'b0;
    logic                 step_pulse   = 1'b0;
    logic                 half_wave    = 1'b0;
    logic                 speed_stall  = 1'b0;
    logic [9:0]           load_level   = 10'h200;
    logic [9:0]           spread_load;
    logic [9:0]           volt_load;
    logic [9:0]           coil_a_on_time;
    logic [7:0]           amp_target   = 8'h00;
    chop_pkg::bridge_s    bridge;
    chop_pkg::scale_req_s scale_req;
    logic                 stall_flag;
    logic                 stst_flag;
    logic [9:0]           load_measure_result;
    logic [7:0]           amplitude;
    logic                 stepping     = 1'b0;
    logic [31:0]          q;
    logic                 err;
    int                   fails        = 0;
    int                   samples_checked = 0;
    int                   cyc          = 0;

    // Clock and step source; steps every fourth cycle while moving
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        step_pulse <= stepping && (cyc % 4 == 0);
    end

    chopper_pwm_config_load_result #(
        .STST_CLOCKS(STST)
    ) chopper_pwm_config_load_result_i (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .voltage_mode(voltage_mode),
        .step_pulse(step_pulse), .half_wave(half_wave),
        .speed_stall(speed_stall), .spread_load(spread_load),
        .volt_load(volt_load), .coil_a_on_time(coil_a_on_time),
        .amp_target(amp_target), .bridge(bridge), .scale_req(scale_req),
        .stall_flag(stall_flag), .stst_flag(stst_flag),
        .load_measure_result(load_measure_result), .amplitude(amplitude));

    coil_model coil_model_i (
        .bridge(bridge), .load_level(load_level),
        .spread_load(spread_load), .volt_load(volt_load),
        .coil_a_on_time(coil_a_on_time));

    // ****************************************
    // Access and compare tasks
    // ****************************************
    // Request held until pready is sampled high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No cycle count assumed; the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Half-wave pulses spaced so the regulator settles between them
    task automatic halfw(input int n);
        repeat (n) begin
            half_wave <= 1'b1;
            @(posedge clk);
            half_wave <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : halfw

    task automatic complete_run;
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        #(5 * 40000);
        fails++;
        complete_run();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, chop_pkg::CFG_ADDR, 32'h0);
        chk("cfg_reset", chop_pkg::CFG_RESET, q);
        // Gradient 4 gives two amplitude LSBs per half wave
        amp_target <= 8'hff;
        halfw(3);
        chk("amp_grad4", 32'h06, amplitude);
        apb(1'b1, chop_pkg::CFG_ADDR, 32'h3f0c001d);
        halfw(40);
        chk("amp_full", 32'hff, amplitude);
        voltage_mode <= 1'b1;
        repeat (4) @(posedge clk);
        chk("amp_cap", 32'h3, amplitude[7:4]);
        apb(1'b1, chop_pkg::CFG_ADDR, 32'hffffffff);
        apb(1'b0, chop_pkg::CFG_ADDR, 32'h0);
        chk("cfg_rw", 32'hffffffff, q);
        apb(1'b1, chop_pkg::CFG_ADDR, chop_pkg::CFG_RESET);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, q);
        // Voltage path must ignore a zero spread reading
        stepping <= 1'b1;
        load_level <= 10'h000;
        apb(1'b1, chop_pkg::CTRL_ADDR, 32'h100);
        repeat (4) @(posedge clk);
        chk("res_volt", 32'h040, load_measure_result);
        chk("no_stall", 32'h0, stall_flag);
        voltage_mode <= 1'b0;
        repeat (4) @(posedge clk);
        chk("res_spread", 32'h000, load_measure_result);
        apb(1'b0, chop_pkg::STATUS_ADDR, 32'h0);
        chk("stat_stall", 32'h01000000, q & 32'h010043ff);
        load_level <= 10'h200;
        apb(1'b1, chop_pkg::CTRL_ADDR, 32'h100);
        chk("stall_clr", 32'h0, stall_flag);
        speed_stall <= 1'b1;
        @(posedge clk);
        speed_stall <= 1'b0;
        repeat (3) @(posedge clk);
        chk("spd_stall", 32'h1, stall_flag);
        apb(1'b1, chop_pkg::LIMITS_ADDR, 32'h00c80064);
        load_level <= 10'd50;
        repeat (4) @(posedge clk);
        chk("scale_inc", 32'h2, scale_req);
        load_level <= 10'd300;
        repeat (4) @(posedge clk);
        chk("scale_dec", 32'h1, scale_req);
        // Standstill: spread path shows coil on-time instead
        stepping <= 1'b0;
        repeat (STST + 8) @(posedge clk);
        chk("stst", 32'h1, stst_flag);
        chk("res_ontime", 32'h155, load_measure_result);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, chop_pkg::CFG_ADDR, chop_pkg::CFG_RESET | (m << 20));
            repeat (2) @(posedge clk);
            chk("coil_mode", m, bridge.coil);
        end
        apb(1'b1, chop_pkg::CTRL_ADDR, 32'h5);
        repeat (2) @(posedge clk);
        chk("coil_hold", 32'h0, bridge.coil);
        apb(1'b1, chop_pkg::CFG_ADDR, chop_pkg::CFG_RESET | 32'h00c00000);
        repeat (2) @(posedge clk);
        chk("reg_hold", 32'h1, bridge.reg_hold);
        chk("sd_meas", 32'h1, bridge.sd_meas);
        stepping <= 1'b1;
        repeat (8) @(posedge clk);
        chk("stst_fall", 32'h0, stst_flag);
        chk("reg_run", 32'h0, bridge.reg_hold);
        complete_run();
    end
endmodule : chopper_pwm_config_load_result_tb
`default_nettype wire
